// ==== rtl/mcu_pin_function_mux.sv ====
// Pin function assignment for three ports, reset, NMI and test pins
module mcu_pin_function_mux (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Port A configuration and pins
    input wire logic [7:0] port_a_data,
    input wire logic [7:0] port_a_dir,
    input wire logic [7:0] port_a_opt,
    input wire logic [7:0] port_a_lines_in,
    output logic [7:0] port_a_lines_out,
    output logic [7:0] port_a_lines_oe,
    output logic [7:0] port_a_pull_up,
    output logic [7:0] port_a_analog_en,
    output logic [7:0] port_a_in,
    // Port B configuration and pins
    input wire logic [7:0] port_b_data,
    input wire logic [7:0] port_b_dir,
    input wire logic [7:0] port_b_opt,
    input wire logic [7:0] port_b_lines_in,
    output logic [7:0] port_b_lines_out,
    output logic [7:0] port_b_lines_oe,
    output logic [7:0] port_b_pull_up,
    output logic [7:0] port_b_in,
    // Port C configuration and pins
    input wire logic [4:0] port_c_data,
    input wire logic [4:0] port_c_dir,
    input wire logic [4:0] port_c_opt,
    input wire logic [4:0] port_c_lines_in,
    output logic [4:0] port_c_lines_out,
    output logic [4:0] port_c_lines_oe,
    output logic [4:0] port_c_pull_up,
    output logic [4:0] port_c_analog_en,
    output logic [4:0] port_c_in,
    // Port interrupt request, one pulse per cycle in which any interrupt line falls
    output logic port_int_req,
    // Auto-reload timer
    input wire logic art_out_sel,
    input wire logic art_out,
    output logic art_in,
    // General timer
    input wire logic gt_sel,
    input wire logic gt_oe,
    input wire logic gt_out,
    output logic gt_in,
    // Serial peripheral interface
    input wire logic spi_sel,
    input wire logic spi_dout,
    input wire logic spi_clk_oe,
    input wire logic spi_clk_out,
    output logic spi_din,
    output logic spi_clk_in,
    // System pins
    input wire logic reset_pin_n,
    input wire logic nmi_pin_n,
    input wire logic test_pin_hv,
    output logic core_rst,
    output logic nmi_req,
    output logic prog_mode
);
    // Alternate function hookup per line
    logic [7:0] b_alt_en; // Port B lines handed to a peripheral
    logic [7:0] b_alt_oe; // Peripheral drive enable, port B
    logic [7:0] b_alt_out; // Peripheral data, port B
    logic [4:0] c_alt_en; // Port C lines handed to a peripheral
    logic [4:0] c_alt_oe; // Peripheral drive enable, port C
    logic [4:0] c_alt_out; // Peripheral data, port C
    logic [7:0] a_int_en; // Interrupt mode, port A
    logic [7:0] b_int_en; // Interrupt mode, port B
    logic [4:0] c_int_en; // Interrupt mode, port C
    logic [7:0] a_prev_reg; // Previous sample for edge detect
    logic [7:0] b_prev_reg;
    logic [4:0] c_prev_reg;
    logic nmi_prev_reg; // Previous NMI pin level
    logic core_rst_reg; // Core reset state
    logic prog_mode_reg; // Programming mode caught at reset release

    // Timer input needs no override: software keeps the timer input line an input
    always_comb begin
        b_alt_en = 8'h00;
        b_alt_oe = 8'h00;
        b_alt_out = 8'h00;
        b_alt_en[pin_mux_pkg::RELOAD_TIMER_OUT_BIT] = art_out_sel;
        b_alt_oe[pin_mux_pkg::RELOAD_TIMER_OUT_BIT] = 1'b1;
        b_alt_out[pin_mux_pkg::RELOAD_TIMER_OUT_BIT] = art_out;
    end

    // Port C alternates: general timer and serial interface
    always_comb begin
        c_alt_en = 5'h00;
        c_alt_oe = 5'h00;
        c_alt_out = 5'h00;
        c_alt_en[pin_mux_pkg::GENERAL_TIMER_BIT] = gt_sel;
        c_alt_oe[pin_mux_pkg::GENERAL_TIMER_BIT] = gt_oe;
        c_alt_out[pin_mux_pkg::GENERAL_TIMER_BIT] = gt_out;
        // Data in is receive only, so the driver is released
        c_alt_en[pin_mux_pkg::SPI_DIN_BIT] = spi_sel;
        c_alt_en[pin_mux_pkg::SPI_DOUT_BIT] = spi_sel;
        c_alt_oe[pin_mux_pkg::SPI_DOUT_BIT] = 1'b1;
        c_alt_out[pin_mux_pkg::SPI_DOUT_BIT] = spi_dout;
        c_alt_en[pin_mux_pkg::SPI_CLK_BIT] = spi_sel;
        c_alt_oe[pin_mux_pkg::SPI_CLK_BIT] = spi_clk_oe;
        c_alt_out[pin_mux_pkg::SPI_CLK_BIT] = spi_clk_out;
    end

    // Port A: all modes including analog
    for (genvar i = 0; i < pin_mux_pkg::PORT_A_WIDTH; i++) begin : g_port_a
        port_line_cell #(.HAS_ANALOG(1'b1)) u_cell (
            .dir_bit(port_a_dir[i]),
            .opt_bit(port_a_opt[i]),
            .data_bit(port_a_data[i]),
            .alt_en(1'b0),
            .alt_oe(1'b0),
            .alt_out(1'b0),
            .pin_out(port_a_lines_out[i]),
            .pin_oe(port_a_lines_oe[i]),
            .pull_up(port_a_pull_up[i]),
            .analog_en(port_a_analog_en[i]),
            .int_en(a_int_en[i])
        );
    end

    // Port B: no analog path on any line
    for (genvar i = 0; i < pin_mux_pkg::PORT_B_WIDTH; i++) begin : g_port_b
        port_line_cell #(.HAS_ANALOG(1'b0)) u_cell (
            .dir_bit(port_b_dir[i]),
            .opt_bit(port_b_opt[i]),
            .data_bit(port_b_data[i]),
            .alt_en(b_alt_en[i]),
            .alt_oe(b_alt_oe[i]),
            .alt_out(b_alt_out[i]),
            .pin_out(port_b_lines_out[i]),
            .pin_oe(port_b_lines_oe[i]),
            .pull_up(port_b_pull_up[i]),
            .analog_en(),
            .int_en(b_int_en[i])
        );
    end

    // Port C: all modes including analog
    for (genvar i = 0; i < pin_mux_pkg::PORT_C_WIDTH; i++) begin : g_port_c
        port_line_cell #(.HAS_ANALOG(1'b1)) u_cell (
            .dir_bit(port_c_dir[i]),
            .opt_bit(port_c_opt[i]),
            .data_bit(port_c_data[i]),
            .alt_en(c_alt_en[i]),
            .alt_oe(c_alt_oe[i]),
            .alt_out(c_alt_out[i]),
            .pin_out(port_c_lines_out[i]),
            .pin_oe(port_c_lines_oe[i]),
            .pull_up(port_c_pull_up[i]),
            .analog_en(port_c_analog_en[i]),
            .int_en(c_int_en[i])
        );
    end

    // Input path sampled every cycle, whatever owns the driver
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_in <= 8'hff;
            port_b_in <= 8'hff;
            port_c_in <= 5'h1f;
        end else begin
            port_a_in <= port_a_lines_in;
            port_b_in <= port_b_lines_in;
            port_c_in <= port_c_lines_in;
        end
    end

    // Peripheral input taps come straight from the sampled port values
    assign art_in = port_b_in[pin_mux_pkg::RELOAD_TIMER_IN_BIT];
    assign gt_in = port_c_in[pin_mux_pkg::GENERAL_TIMER_BIT];
    assign spi_din = port_c_in[pin_mux_pkg::SPI_DIN_BIT];
    assign spi_clk_in = port_c_in[pin_mux_pkg::SPI_CLK_BIT];

    // Falling edge on any interrupt-mode line gives one pulse
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            a_prev_reg <= 8'hff;
            b_prev_reg <= 8'hff;
            c_prev_reg <= 5'h1f;
            port_int_req <= 1'b0;
        end else begin
            a_prev_reg <= port_a_in;
            b_prev_reg <= port_b_in;
            c_prev_reg <= port_c_in;
            port_int_req <= (|(a_prev_reg & ~port_a_in & a_int_en))
                | (|(b_prev_reg & ~port_b_in & b_int_en))
                | (|(c_prev_reg & ~port_c_in & c_int_en));
        end
    end

    // NMI edge detect; there is deliberately no mask input at all
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_prev_reg <= pin_mux_pkg::NMI_IDLE_RESET;
            nmi_req <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_pin_n;
            nmi_req <= nmi_prev_reg & ~nmi_pin_n;
        end
    end

    // Reset pin held low keeps the core in reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_rst_reg <= pin_mux_pkg::CORE_RST_RESET;
        end else begin
            core_rst_reg <= ~reset_pin_n;
        end
    end
    assign core_rst = core_rst_reg;

    // Test pin tracked through reset, frozen when the core starts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_mode_reg <= pin_mux_pkg::PROG_MODE_RESET;
        end else if (core_rst_reg) begin
            prog_mode_reg <= test_pin_hv;
        end
    end
    assign prog_mode = prog_mode_reg;

    AST_A_PUSH_PULL: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((port_a_lines_oe & port_a_dir & port_a_opt) == (port_a_dir & port_a_opt))
        && ((port_a_lines_out & port_a_dir & port_a_opt)
        == (port_a_data & port_a_dir & port_a_opt)))
        else $error("Port A push-pull line not driven with its data");
    AST_C_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((port_c_lines_out & port_c_dir & ~port_c_opt & ~c_alt_en) == 5'h00))
        else $error("Port C open-drain line drives high");
    AST_B_ANALOG_NONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        // Only the analog code, not the pulled-up interrupt code that shares dir and opt
        (port_b_dir == 8'h00 && port_b_opt == 8'hff && port_b_data == 8'hff && !art_out_sel)
        |-> (port_b_lines_oe == 8'h00 && port_b_pull_up == 8'h00))
        else $error("Port B line misbehaves in analog setting");
    AST_TIMER_OUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        art_out_sel |-> (port_b_lines_oe[7] && port_b_lines_out[7] == art_out))
        else $error("Timer output not on port B line 7");
    AST_GT_LINE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        gt_sel |-> (port_c_lines_oe[1] == gt_oe && port_c_lines_out[1] == gt_out))
        else $error("General timer not routed to port C line 1");
    AST_SPI_LINES: assert property (@(posedge sys_clk) disable iff (sys_rst)
        spi_sel |-> (!port_c_lines_oe[2] && port_c_lines_oe[3]
        && port_c_lines_out[3] == spi_dout && port_c_lines_oe[4] == spi_clk_oe))
        else $error("Serial lines not routed to port C");
    AST_NMI_EDGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (nmi_prev_reg && !nmi_pin_n) |=> nmi_req ##1 !nmi_req)
        else $error("NMI falling edge not reported as one pulse");
    AST_RESET_PIN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !reset_pin_n |=> core_rst)
        else $error("Reset pin low did not hold core reset");
    AST_PROG_CATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(core_rst) |-> (prog_mode == $past(test_pin_hv)) ##1 $stable(prog_mode))
        else $error("Programming mode not caught at reset release");
    AST_INPUT_PATH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 (port_c_in == $past(port_c_lines_in) && port_b_in == $past(port_b_lines_in)))
        else $error("Input path does not follow pins");
endmodule

// ==== rtl/pin_mux_pkg.sv ====
package pin_mux_pkg;
    // Line widths of the three ports
    localparam int PORT_A_WIDTH = 8;
    localparam int PORT_B_WIDTH = 8;
    localparam int PORT_C_WIDTH = 5;
    // Alternate function line positions
    localparam int RELOAD_TIMER_IN_BIT = 6;
    localparam int RELOAD_TIMER_OUT_BIT = 7;
    localparam int GENERAL_TIMER_BIT = 1;
    localparam int SPI_DIN_BIT = 2;
    localparam int SPI_DOUT_BIT = 3;
    localparam int SPI_CLK_BIT = 4;
    // Values after reset
    localparam logic CORE_RST_RESET = 1'b1;
    localparam logic PROG_MODE_RESET = 1'b0;
    localparam logic NMI_IDLE_RESET = 1'b1;

    // Line mode, coded as {direction, option, data}
    typedef enum logic [2:0] {
        MODE_IN_PULLUP = 3'b000,
        MODE_IN_FLOAT = 3'b001,
        MODE_IN_INT = 3'b010,
        MODE_IN_ANALOG = 3'b011,
        MODE_OUT_OD_LOW = 3'b100,
        MODE_OUT_OD_HIGH = 3'b101,
        MODE_OUT_PP_LOW = 3'b110,
        MODE_OUT_PP_HIGH = 3'b111
    } line_mode_t;
endpackage

// ==== rtl/port_line_cell.sv ====
// One port line: mode decode plus alternate function override
module port_line_cell #(
    parameter bit HAS_ANALOG = 1'b1
) (
    input wire logic dir_bit,
    input wire logic opt_bit,
    input wire logic data_bit,
    input wire logic alt_en,
    input wire logic alt_oe,
    input wire logic alt_out,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up,
    output logic analog_en,
    output logic int_en
);
    pin_mux_pkg::line_mode_t mode; // Decoded line mode

    // Port mode decode; the alternate function takes the driver and clears analog and interrupt mode
    always_comb begin
        mode = pin_mux_pkg::line_mode_t'({dir_bit, opt_bit, data_bit});
        pin_out = 1'b0;
        pin_oe = 1'b0;
        pull_up = 1'b0;
        analog_en = 1'b0;
        int_en = 1'b0;
        case (mode)
            pin_mux_pkg::MODE_IN_PULLUP: begin
                pull_up = 1'b1;
            end
            pin_mux_pkg::MODE_IN_FLOAT: begin
                pull_up = 1'b0;
            end
            pin_mux_pkg::MODE_IN_INT: begin
                pull_up = 1'b1;
                int_en = 1'b1;
            end
            pin_mux_pkg::MODE_IN_ANALOG: begin
                // Without an analog path the line falls back to a floating input
                analog_en = HAS_ANALOG;
            end
            pin_mux_pkg::MODE_OUT_OD_LOW: begin
                // Open drain only ever pulls low
                pin_oe = 1'b1;
            end
            pin_mux_pkg::MODE_OUT_OD_HIGH: begin
                pin_oe = 1'b0;
            end
            pin_mux_pkg::MODE_OUT_PP_LOW: begin
                pin_oe = 1'b1;
            end
            pin_mux_pkg::MODE_OUT_PP_HIGH: begin
                pin_oe = 1'b1;
                pin_out = 1'b1;
            end
            default: begin
                pin_oe = 1'b0;
            end
        endcase
        // Peripheral owns the driver; input path stays untouched
        if (alt_en) begin
            pin_oe = alt_oe;
            pin_out = alt_out;
            analog_en = 1'b0;
            int_en = 1'b0;
        end
    end
endmodule

// ==== bench/board_port_model.sv ====
// Board side of one port: external drivers, pull-ups and floating lines
module board_port_model #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic [W-1:0] lines_out,
    input wire logic [W-1:0] lines_oe,
    input wire logic [W-1:0] pull_up,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] lines_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Undriven, unpulled lines wander; a toggling pattern keeps tests honest
    logic [W-1:0] float_reg = '0;

    // Floating pattern changes every cycle
    always @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end

    // Wire level from every party; contention gives an unknown on purpose
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (lines_oe[i] && ext_en[i]) begin
                lines_in[i] = 1'bx;
            end else if (lines_oe[i]) begin
                lines_in[i] = lines_out[i];
            end else if (ext_en[i]) begin
                lines_in[i] = ext_val[i];
            end else if (pull_up[i]) begin
                lines_in[i] = 1'b1;
            end else begin
                lines_in[i] = float_reg[i];
            end
        end
    end
endmodule

// ==== bench/tb_mcu_pin_function_mux.sv ====
// Self-checking bench for the pin function multiplexer
module tb_mcu_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic [7:0] a_data = '0, a_dir = '0, a_opt = '0, a_en = '0, a_val = '0;
    logic [7:0] b_data = '0, b_dir = '0, b_opt = '0, b_en = '0, b_val = '0;
    logic [4:0] c_data = '0, c_dir = '0, c_opt = '0, c_en = '0, c_val = '0;
    logic [7:0] a_lin, a_out, a_oe, a_pu, a_an, a_in, b_lin, b_out, b_oe, b_pu, b_in;
    logic [4:0] c_lin, c_out, c_oe, c_pu, c_an, c_in;
    logic art_sel = 0, art_o = 0, gt_sel = 0, gt_oe = 0, gt_o = 0;
    logic spi_sel = 0, spi_do = 0, spi_ck_oe = 0, spi_ck_o = 0;
    logic rst_pin_n = 1, nmi_n = 1, test_hv = 0; // Test pin grounded
    logic int_req, art_in, gt_in, spi_din, spi_ck_in, core_rst, nmi_req, prog_mode;
    int miscompares = 0, n_compared = 0, cycles = 0, k;
    logic [3:0] e;

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    mcu_pin_function_mux u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .port_a_data(a_data), .port_a_dir(a_dir), .port_a_opt(a_opt),
        .port_a_lines_in(a_lin), .port_a_lines_out(a_out), .port_a_lines_oe(a_oe),
        .port_a_pull_up(a_pu), .port_a_analog_en(a_an), .port_a_in(a_in),
        .port_b_data(b_data), .port_b_dir(b_dir), .port_b_opt(b_opt),
        .port_b_lines_in(b_lin), .port_b_lines_out(b_out), .port_b_lines_oe(b_oe),
        .port_b_pull_up(b_pu), .port_b_in(b_in),
        .port_c_data(c_data), .port_c_dir(c_dir), .port_c_opt(c_opt),
        .port_c_lines_in(c_lin), .port_c_lines_out(c_out), .port_c_lines_oe(c_oe),
        .port_c_pull_up(c_pu), .port_c_analog_en(c_an), .port_c_in(c_in),
        .port_int_req(int_req), .art_out_sel(art_sel), .art_out(art_o), .art_in(art_in),
        .gt_sel(gt_sel), .gt_oe(gt_oe), .gt_out(gt_o), .gt_in(gt_in),
        .spi_sel(spi_sel), .spi_dout(spi_do), .spi_clk_oe(spi_ck_oe),
        .spi_clk_out(spi_ck_o), .spi_din(spi_din), .spi_clk_in(spi_ck_in),
        .reset_pin_n(rst_pin_n), .nmi_pin_n(nmi_n), .test_pin_hv(test_hv),
        .core_rst(core_rst), .nmi_req(nmi_req), .prog_mode(prog_mode));

    // Board models for the three ports
    board_port_model #(.W(8)) u_brd_a (.sys_clk(sys_clk), .lines_out(a_out),
        .lines_oe(a_oe), .pull_up(a_pu), .ext_en(a_en), .ext_val(a_val), .lines_in(a_lin));
    board_port_model #(.W(8)) u_brd_b (.sys_clk(sys_clk), .lines_out(b_out),
        .lines_oe(b_oe), .pull_up(b_pu), .ext_en(b_en), .ext_val(b_val), .lines_in(b_lin));
    board_port_model #(.W(5)) u_brd_c (.sys_clk(sys_clk), .lines_out(c_out),
        .lines_oe(c_oe), .pull_up(c_pu), .ext_en(c_en), .ext_val(c_val), .lines_in(c_lin));

    // Verdict and end of run
    task automatic end_sim();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One comparison, reported at once on mismatch
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    // Same mode on every line of every port, applied at a rising edge
    task automatic set_mode(input logic [2:0] m);
        @(posedge sys_clk);
        {a_dir, a_opt, a_data} <= {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        {b_dir, b_opt, b_data} <= {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        {c_dir, c_opt, c_data} <= {{5{m[2]}}, {5{m[1]}}, {5{m[0]}}};
    endtask

    // Expected {oe, out, pull-up, analog} for a mode code
    function automatic logic [3:0] exp_bits(input logic [2:0] m);
        return {m[2] && (m[1:0] != 2'b01), m[0], (m == 3'h0) || (m == 3'h2), m == 3'h3};
    endfunction

    // Counts one-cycle pulses of the interrupt (0) or NMI (1) request
    task automatic count_pulses(input int which, input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (which == 0 ? int_req === 1'b1 : nmi_req === 1'b1) begin
                cnt++;
            end
        end
    endtask

    // Hang guard, well above the length of the sequence below
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("core_rst_in_reset", 8'h01, {7'h0, core_rst});
        chk("prog_in_reset", 8'h00, {7'h0, prog_mode});
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Every mode code on every line of the three ports
        for (int m = 0; m < 8; m++) begin
            set_mode(3'(m));
            @(negedge sys_clk);
            e = exp_bits(3'(m));
            chk("a_oe", {8{e[3]}}, a_oe);
            chk("a_out", {8{e[3] & e[2]}}, a_out & a_oe);
            chk("a_pu", {8{e[1]}}, a_pu);
            chk("a_an", {8{e[0]}}, a_an);
            chk("b_oe", {8{e[3]}}, b_oe);
            chk("b_out", {8{e[3] & e[2]}}, b_out & b_oe);
            chk("b_pu", {8{e[1]}}, b_pu);
            chk("c_oe", {3'h0, {5{e[3]}}}, {3'h0, c_oe});
            chk("c_pu", {3'h0, {5{e[1]}}}, {3'h0, c_pu});
            chk("c_an", {3'h0, {5{e[0]}}}, {3'h0, c_an});
        end
        // Pin levels reach the input path; timer input line set as input
        set_mode(3'h0);
        {a_en, a_val, b_en, b_val, c_en, c_val} <= {8'hff, 8'h5a, 8'hff, 8'ha5, 5'h1f, 5'h13};
        repeat (2) @(negedge sys_clk);
        chk("a_in", 8'h5a, a_in);
        chk("b_in", 8'ha5, b_in);
        chk("c_in", 8'h13, {3'h0, c_in});
        chk("art_in", 8'h00, {7'h0, art_in});
        // Falling edge on an interrupt line gives a single pulse
        set_mode(3'h2);
        a_val <= 8'hff;
        repeat (3) @(posedge sys_clk);
        a_val <= 8'hfe;
        count_pulses(0, 6, k);
        chk("int_pulses", 8'h01, 8'(k));
        // Timer output, general timer and serial lines on their alternate lines
        set_mode(3'h7);
        // Board drivers released at the same edge that applies the push-pull mode
        {a_en, b_en, c_en, art_sel, art_o, gt_sel, gt_oe, gt_o} <= {8'h00, 8'h00, 5'h00, 5'b11101};
        {spi_sel, spi_do, spi_ck_oe, spi_ck_o} <= 4'b1110;
        @(negedge sys_clk);
        chk("timer_out_drive", 8'h80, b_oe & b_out & 8'h80);
        chk("pc_alt", 8'h18, {3'h0, c_oe & 5'h1e});
        chk("pc_alt_out", 8'h08, {3'h0, c_out & c_oe & 5'h1e});
        @(posedge sys_clk);
        // Peripheral data low while the port data stays high shows who owns the line
        {gt_oe, spi_ck_oe, spi_do, c_en, c_val, art_o} <= {3'b000, 5'h16, 5'h14, 1'b0};
        repeat (2) @(negedge sys_clk);
        chk("timer_out_level", 8'h00, b_out & b_oe & 8'h80);
        chk("gt_in", 8'h00, {7'h0, gt_in});
        chk("spi_in", 8'h03, {6'h0, spi_din, spi_ck_in});
        chk("spi_dout_level", 8'h00, {3'h0, c_out & c_oe & 5'h08});
        // Non-maskable interrupt: one pulse per falling edge
        @(posedge sys_clk);
        nmi_n <= 1'b0;
        count_pulses(1, 6, k);
        chk("nmi_pulses", 8'h01, 8'(k));
        // Reset pin with the test pin at programming level
        @(posedge sys_clk);
        {rst_pin_n, test_hv, nmi_n} <= 3'b011;
        repeat (2) @(negedge sys_clk);
        chk("core_rst_low_pin", 8'h01, {7'h0, core_rst});
        @(posedge sys_clk);
        rst_pin_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("core_rst_released", 8'h00, {7'h0, core_rst});
        chk("prog_entered", 8'h01, {7'h0, prog_mode});
        @(posedge sys_clk);
        {rst_pin_n, test_hv} <= 2'b00;
        @(posedge sys_clk);
        rst_pin_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("prog_normal", 8'h00, {7'h0, prog_mode});
        end_sim();
    end
endmodule
